// [rtl/snvf_regs.svh]
`ifndef SNVF_REGS_SVH
`define SNVF_REGS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SNVF_OP_WRSR      8'h01
`define SNVF_OP_WRITE     8'h02
`define SNVF_OP_READ      8'h03
`define SNVF_OP_WR_DISABLE 8'h04
`define SNVF_OP_RDSR      8'h05
`define SNVF_OP_WREN      8'h06
`define SNVF_OP_FREAD     8'h0B
`define SNVF_OP_STORE     8'h3C
`define SNVF_OP_RECALL    8'h60
`define SNVF_OP_ASOFF     8'h19
`define SNVF_OP_ASON      8'h59
// ----------------------------------------
// Status fields
// ----------------------------------------
`define SNVF_SR_RDY       0
`define SNVF_SR_WEL       1
`define SNVF_SR_BP_LO     2
`define SNVF_SR_BP_HI     3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SNVF_CLK_MHZ      250
`define SNVF_STORE_NS     2000
`define SNVF_RECALL_NS    1000
`define SNVF_RELEASE_NS   100
`define SNVF_STORE_CYC    ((`SNVF_STORE_NS * `SNVF_CLK_MHZ) / 1000)
`define SNVF_RECALL_CYC   ((`SNVF_RECALL_NS * `SNVF_CLK_MHZ) / 1000)
`define SNVF_RELEASE_CYC  ((`SNVF_RELEASE_NS * `SNVF_CLK_MHZ) / 1000)
`endif

// [rtl/snvf_pkg.sv]
package snvf_pkg;
    typedef enum logic [2:0] {SNVF_IDLE, SNVF_OPC, SNVF_ADDR, SNVF_DUMMY, SNVF_WDATA, SNVF_RDATA, SNVF_WSR,
                              SNVF_DONE} snvf_spi_e;
    typedef enum logic [1:0] {SNVF_NV_IDLE, SNVF_NV_STORE, SNVF_NV_RECALL, SNVF_NV_RELEASE} snvf_nv_e;
    typedef struct packed {
        logic        wr;
        logic [14:0] addr;
        logic [7:0]  data;
    } snvf_req_s;
endpackage

// [rtl/snvf_front_end.sv]
`timescale 1ns/100ps
`include "snvf_regs.svh"
// Notes on behaviour
// - Serial traffic only while select is low
// - Select high gives standby, ends transfer
// - Sample input rising, launch output falling
// - Slave only, modes zero and three
// - Array of 32K bytes
// - Ordinary access up to 40 MHz, no waits
// - Fast read only adds a dummy byte; same 250 MHz sampling and launch lag as read
// - Host access touches only volatile array
// - Save copies whole array in parallel
// - Busy pin low during save
// - Drive busy pin high briefly, then release
// - External low on busy pin requests save
// - Hold freezes transfer, keeps partial state
// - Write protect by pin and disable command
// - Two bits protect none, quarter, half, all
// - Decode save, restore, autosave off/on
// - Refuse memory access during save or restore
// - Busy shown on pin and status flag
// - Busy pin, protect pin, autosave are optional
// - Ready/busy flag one while operation runs
// - Hardware/auto save skipped unless written since
module snvf_front_end
    import snvf_pkg::*;
#(
    parameter int ADDR_W     = 15,
    parameter int DEPTH      = 32768,
    parameter bit HAS_BUSY   = 1'b1,
    parameter bit HAS_WP     = 1'b1,
    parameter bit HAS_AUTO   = 1'b1
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    input  wire logic wp_n,
    input  wire logic hold_n,
    input  wire logic store_busy_pin_i,
    output logic      store_busy_pin_o,
    output logic      store_busy_pin_oe,
    input  wire logic power_fail,
    output logic      busy,
    output logic      autosave_en
);
    if (ADDR_W != 15 || DEPTH != (1 << ADDR_W)) begin : g_bad_size
        $error("snvf_front_end: array must be 2**ADDR_W bytes, 15 bits");
    end

    // ----------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_r;
    logic       rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rst_r <= 2'h0;
        else         rst_r <= {rst_r[0], 1'b1};
    end
    assign rst_n = rst_r[1];

    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_a_r, pin_b_r, pin_c_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels, so that no false edge follows reset
            pin_a_r <= 7'h1E;
            pin_b_r <= 7'h1E;
            pin_c_r <= 7'h1E;
        end else begin
            pin_a_r <= {1'b1, power_fail, store_busy_pin_i, hold_n, wp_n, cs_n, sck} ^ 7'h40;
            pin_b_r <= pin_a_r;
            pin_c_r <= pin_b_r;
        end
    end
    logic sck_s, cs_s, wp_s, hold_s, sbp_s, pf_s, sck_p;
    assign sck_s  = pin_b_r[0];
    assign sck_p  = pin_c_r[0];
    assign cs_s   = pin_b_r[1];
    assign wp_s   = HAS_WP ? pin_b_r[2] : 1'b1;
    assign hold_s = pin_b_r[3];
    assign sbp_s  = HAS_BUSY ? pin_b_r[4] : 1'b1;
    assign pf_s   = HAS_AUTO ? pin_b_r[5] : 1'b0;
    logic si_a_r, si_b_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            si_a_r <= 1'b0;
            si_b_r <= 1'b0;
        end else begin
            si_a_r <= si;
            si_b_r <= si_a_r;
        end
    end

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic active, rise, fall;
    assign active = !cs_s && hold_s;
    assign rise   = active && sck_s && !sck_p;
    assign fall   = active && !sck_s && sck_p;

    // ----------------------------------------
    // Storage, flip-flops only
    // ----------------------------------------
    logic [7:0] sram_r [DEPTH];
    logic [7:0] nv_r   [DEPTH];

    // ----------------------------------------
    // Two-entry write buffer
    // ----------------------------------------
    snvf_req_s buf_r [2];
    logic [1:0] buf_cnt_r;
    logic       buf_wp_r, buf_rp_r;
    logic       in_valid, in_ready, out_valid, out_ready;
    snvf_req_s  in_req;
    assign in_ready  = buf_cnt_r != 2'h2;
    assign out_valid = buf_cnt_r != 2'h0;

    // ----------------------------------------
    // Nonvolatile sequencer
    // ----------------------------------------
    snvf_nv_e nv_r_st;
    logic [31:0] nv_cnt_r;
    logic dirty_r, sw_store, sw_recall, sbp_p_r, pf_p_r;
    logic hw_req, auto_req, nv_busy;
    assign hw_req   = HAS_BUSY && !sbp_s && sbp_p_r && dirty_r && nv_r_st == SNVF_NV_IDLE;
    assign auto_req = HAS_AUTO && autosave_en && pf_s && !pf_p_r && dirty_r;
    assign nv_busy  = nv_r_st == SNVF_NV_STORE || nv_r_st == SNVF_NV_RECALL;
    assign busy     = nv_busy;
    assign out_ready = !nv_busy;                     // stalls pending writes

    // ----------------------------------------
    // Serial state
    // ----------------------------------------
    snvf_spi_e st_r;
    logic [7:0]  opc_r, sh_r, sr_tx_r;
    logic [2:0]  bit_r;
    logic [15:0] addr_r;
    logic        abyte_r, wel_r, so_r;
    logic [1:0]  bp_r;

    function automatic logic prot(input logic [1:0] bp, input logic [14:0] a);
        unique case (bp)
            2'h0: prot = 1'b0;
            2'h1: prot = a[14:13] == 2'h3;
            2'h2: prot = a[14];
            2'h3: prot = 1'b1;
        endcase
    endfunction

    logic [7:0] byte_in;
    logic       byte_done, wr_ok;
    assign byte_in   = {sh_r[6:0], si_b_r};
    assign byte_done = rise && bit_r == 3'h7;
    assign wr_ok     = wel_r && !prot(bp_r, addr_r[14:0]) && !nv_busy;
    assign in_valid  = st_r == SNVF_WDATA && byte_done && wr_ok;
    assign in_req    = '{wr: 1'b1, addr: addr_r[14:0], data: byte_in};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= SNVF_IDLE; opc_r <= 8'h00; sh_r <= 8'h00; bit_r <= 3'h0;
            addr_r <= 16'h0000; abyte_r <= 1'b0; wel_r <= 1'b0; bp_r <= 2'h0;
            autosave_en <= 1'b1; sw_store <= 1'b0; sw_recall <= 1'b0;
        end else begin
            sw_store  <= 1'b0;
            sw_recall <= 1'b0;
            if (cs_s) begin
                st_r  <= SNVF_OPC;
                bit_r <= 3'h0;
            end else if (rise) begin                 // no wait states
                sh_r  <= byte_in;
                bit_r <= bit_r + 3'h1;
                if (bit_r == 3'h7) begin
                    unique case (st_r)
                        SNVF_OPC: begin
                            opc_r <= byte_in; abyte_r <= 1'b0; st_r <= SNVF_DONE;
                            unique case (byte_in)
                                `SNVF_OP_READ, `SNVF_OP_FREAD, `SNVF_OP_WRITE:
                                    st_r <= nv_busy ? SNVF_DONE : SNVF_ADDR;
                                `SNVF_OP_RDSR:   st_r <= SNVF_RDATA;
                                `SNVF_OP_WRSR:   st_r <= wel_r ? SNVF_WSR : SNVF_DONE;
                                `SNVF_OP_WREN:   wel_r <= wp_s;
                                `SNVF_OP_WR_DISABLE: wel_r <= 1'b0;
                                `SNVF_OP_STORE:  sw_store  <= !nv_busy;
                                `SNVF_OP_RECALL: sw_recall <= !nv_busy;
                                `SNVF_OP_ASOFF:  autosave_en <= 1'b0;
                                `SNVF_OP_ASON:   autosave_en <= HAS_AUTO;
                                default: ;
                            endcase
                        end
                        SNVF_ADDR: begin
                            addr_r  <= {addr_r[7:0], byte_in};
                            abyte_r <= 1'b1;
                            if (abyte_r)
                                st_r <= opc_r == `SNVF_OP_WRITE ? SNVF_WDATA :
                                        opc_r == `SNVF_OP_FREAD ? SNVF_DUMMY : SNVF_RDATA;
                        end
                        SNVF_DUMMY: st_r <= SNVF_RDATA;
                        SNVF_WDATA: addr_r <= {1'b0, addr_r[14:0] + 15'h1};
                        SNVF_RDATA: addr_r <= {1'b0, addr_r[14:0] + 15'h1};
                        SNVF_WSR: begin
                            bp_r <= {byte_in[`SNVF_SR_BP_HI], byte_in[`SNVF_SR_BP_LO]};
                            wel_r <= 1'b0;
                            st_r  <= SNVF_DONE;
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // Output shifter, launched on falling edge
    // ----------------------------------------
    logic [7:0] rd_byte;
    assign rd_byte = opc_r == `SNVF_OP_RDSR ?
                     {4'h0, bp_r, wel_r, nv_busy} :
                     (nv_busy ? 8'h00 : sram_r[addr_r[14:0]]);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            so_r <= 1'b0; sr_tx_r <= 8'h00;
        end else if (fall && st_r == SNVF_RDATA) begin
            so_r    <= bit_r == 3'h0 ? rd_byte[7] : sr_tx_r[7];
            sr_tx_r <= bit_r == 3'h0 ? {rd_byte[6:0], 1'b0} : {sr_tx_r[6:0], 1'b0};
        end
    end
    assign so    = so_r;
    assign so_oe = !cs_s;

    // ----------------------------------------
    // Buffer and array
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_cnt_r <= 2'h0; buf_wp_r <= 1'b0; buf_rp_r <= 1'b0;
            buf_r[0] <= '0; buf_r[1] <= '0;
        end else begin
            if (in_valid && in_ready) begin
                buf_r[buf_wp_r] <= in_req;
                buf_wp_r <= !buf_wp_r;
            end
            if (out_valid && out_ready) buf_rp_r <= !buf_rp_r;
            buf_cnt_r <= buf_cnt_r + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
        end
    end

    always_ff @(posedge clk) begin
        if (nv_r_st == SNVF_NV_RECALL && nv_cnt_r == 32'h0) begin
            for (int i = 0; i < DEPTH; i++) sram_r[i] <= nv_r[i];
        end else if (out_valid && out_ready) begin
            sram_r[buf_r[buf_rp_r].addr] <= buf_r[buf_rp_r].data;
        end
        if (nv_r_st == SNVF_NV_STORE && nv_cnt_r == 32'h0) begin
            for (int i = 0; i < DEPTH; i++) nv_r[i] <= sram_r[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_r_st <= SNVF_NV_IDLE; nv_cnt_r <= 32'h0; dirty_r <= 1'b0;
            sbp_p_r <= 1'b1; pf_p_r <= 1'b0;
        end else begin
            sbp_p_r <= sbp_s;
            pf_p_r  <= pf_s;
            unique case (nv_r_st)
                SNVF_NV_IDLE: begin
                    if (sw_store || hw_req || auto_req) begin
                        nv_r_st <= SNVF_NV_STORE; nv_cnt_r <= 32'(`SNVF_STORE_CYC);
                    end else if (sw_recall) begin
                        nv_r_st <= SNVF_NV_RECALL; nv_cnt_r <= 32'(`SNVF_RECALL_CYC);
                    end
                end
                SNVF_NV_STORE, SNVF_NV_RECALL: begin
                    nv_cnt_r <= nv_cnt_r - 32'h1;
                    if (nv_cnt_r == 32'h0) begin
                        dirty_r  <= 1'b0;
                        nv_r_st  <= nv_r_st == SNVF_NV_STORE ? SNVF_NV_RELEASE : SNVF_NV_IDLE;
                        nv_cnt_r <= 32'(`SNVF_RELEASE_CYC);
                    end
                end
                SNVF_NV_RELEASE: begin
                    nv_cnt_r <= nv_cnt_r - 32'h1;
                    if (nv_cnt_r == 32'h1) nv_r_st <= SNVF_NV_IDLE;
                end
            endcase
            // A write in the cycle a save ends must still mark the array
            if (out_valid && out_ready) dirty_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Busy pin: open drain low while busy, brief high drive after a save only
    // ----------------------------------------
    assign store_busy_pin_o  = nv_r_st == SNVF_NV_RELEASE;
    assign store_busy_pin_oe = HAS_BUSY && (nv_busy || nv_r_st == SNVF_NV_RELEASE);
endmodule

// [sim/snvf_front_end_sva.sv]
`timescale 1ns/100ps
`include "snvf_regs.svh"
module snvf_front_end_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic hold_n,
    input wire logic store_busy_pin_i,
    input wire logic store_busy_pin_o,
    input wire logic store_busy_pin_oe,
    input wire logic power_fail,
    input wire logic busy,
    input wire logic autosave_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    localparam int REL_TAIL = `SNVF_RELEASE_CYC - 8;
    // Busy length tells a save from a restore; only a save ends in a high drive
    logic [15:0] busy_len_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_len_r <= 16'h0000;
        end else begin
            busy_len_r <= busy ? busy_len_r + 16'h0001 : 16'h0000;
        end
    end
    property p_so_float; cs_n [*6] |-> !so_oe; endproperty
    a_so_float: assert property (p_so_float) else $error("so driven while deselected");
    property p_so_drive; !cs_n [*6] |-> so_oe; endproperty
    a_so_drive: assert property (p_so_drive) else $error("so idle while selected");
    property p_pin_low; busy == (store_busy_pin_oe && !store_busy_pin_o); endproperty
    a_pin_low: assert property (p_pin_low) else $error("busy pin low without busy");
    property p_rel_start;
        $fell(busy) && $past(store_busy_pin_oe) && busy_len_r > 16'(`SNVF_RECALL_CYC + 2)
            |-> ##[0:2] (store_busy_pin_oe && store_busy_pin_o);
    endproperty
    a_rel_start: assert property (p_rel_start) else $error("no high drive after save");
    property p_rel_end;
        $rose(store_busy_pin_oe && store_busy_pin_o) |-> (store_busy_pin_oe && store_busy_pin_o) [*8]
            ##REL_TAIL (store_busy_pin_oe && store_busy_pin_o) ##1 !store_busy_pin_oe;
    endproperty
    a_rel_end: assert property (p_rel_end) else $error("release interval length wrong");
    property p_busy_len; $rose(busy) |-> busy [*8]; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy flag dropped early");
    property p_auto_off; $rose(power_fail) && !autosave_en && !busy && cs_n && store_busy_pin_i |=> !busy [*8]; endproperty
    a_auto_off: assert property (p_auto_off) else $error("save while autosave off");
    property p_hold; !hold_n [*6] |-> $stable(so); endproperty
    a_hold: assert property (p_hold) else $error("so moved during hold");
endmodule
bind snvf_front_end snvf_front_end_sva u_sva (.clk(clk), .resetn(resetn), .cs_n(cs_n), .so(so), .so_oe(so_oe),
    .hold_n(hold_n), .store_busy_pin_i(store_busy_pin_i), .store_busy_pin_o(store_busy_pin_o),
    .store_busy_pin_oe(store_busy_pin_oe), .power_fail(power_fail), .busy(busy), .autosave_en(autosave_en));

// [sim/snvf_host_model.sv]
`timescale 1ns/100ps
module snvf_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    logic cpol = 1'b0;
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    task automatic start();
        sck  = cpol;
        #16;
        cs_n = 1'b0;
        #16;
    endtask
    // Output is taken late in the high half, well after the launch lag
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si  = tx[i];
            #16 sck = 1'b1;
            #12 rx[i] = so;
            #4;
        end
    endtask
    task automatic stop();
        #16 sck = cpol;
        #16 cs_n = 1'b1;
        // Released line must not keep showing the last bit
        si = ~si;
        #32;
    endtask
endmodule

// [sim/snvf_front_end_tb_top.sv]
`timescale 1ns/100ps
`include "snvf_regs.svh"
module snvf_front_end_tb_top;
    localparam logic [15:0] PA [3] = '{16'h6000, 16'h4000, 16'h0000};
    localparam logic [7:0]  OLD [3] = '{8'h44, 8'h44, 8'hC3};
    logic       clk;
    logic       resetn;
    logic       wp_n;
    logic       hold_n;
    logic       power_fail;
    logic       ext_low;
    wire        sck, cs_n, si, so, so_oe, bsy_o, bsy_oe, busy, autosave_en, pin_lvl;
    int         num_errors;
    int         n_tests;
    logic [7:0] q[$];
    // Open-drain busy pin with weak pull-up
    assign pin_lvl = bsy_oe ? bsy_o : ~ext_low;
    snvf_front_end u_snvf_front_end (.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .store_busy_pin_i(pin_lvl), .store_busy_pin_o(bsy_o),
        .store_busy_pin_oe(bsy_oe), .power_fail(power_fail), .busy(busy), .autosave_en(autosave_en));
    snvf_host_model u_snvf_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; n < lim && busy !== lvl; n++) @(negedge clk);
        if (busy !== lvl) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic frm(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] r;
        rx = {};
        u_snvf_host_model.start();
        foreach (tx[i]) begin
            u_snvf_host_model.xfer(tx[i], r);
            rx.push_back(r);
        end
        u_snvf_host_model.stop();
    endtask
    task automatic op(input logic [7:0] c);
        frm('{c}, q);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        op(`SNVF_OP_WREN);
        frm('{`SNVF_OP_WRITE, a[15:8], a[7:0], v}, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        frm('{`SNVF_OP_READ, a[15:8], a[7:0], 8'h00}, q);
        chk(q[3], e);
    endtask
    task automatic wrsr(input logic [7:0] v);
        op(`SNVF_OP_WREN);
        frm('{`SNVF_OP_WRSR, v}, q);
    endtask
    task automatic t_rw();
        op(`SNVF_OP_WREN);
        frm('{`SNVF_OP_WRITE, 8'h7F, 8'hFF, 8'h5A, 8'hC3}, q);
        rd(16'h7FFF, 8'h5A);
        rd(16'h0000, 8'hC3);
        u_snvf_host_model.cpol = 1'b1;
        frm('{`SNVF_OP_FREAD, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00}, q);
        u_snvf_host_model.cpol = 1'b0;
        chk(q[4], 8'h5A);
        chk(q[5], 8'hC3);
    endtask
    task automatic t_prot();
        wr(16'h0100, 8'h22);
        wr(16'h6000, 8'h44);
        wr(16'h4000, 8'h44);
        wp_n = 1'b0;
        wr(16'h0100, 8'h11);
        wp_n = 1'b1;
        rd(16'h0100, 8'h22);
        op(`SNVF_OP_WREN);
        op(`SNVF_OP_WR_DISABLE);
        frm('{`SNVF_OP_WRITE, 8'h01, 8'h00, 8'h33}, q);
        rd(16'h0100, 8'h22);
        for (int b = 1; b < 4; b++) begin
            wrsr({4'h0, b[1:0], 2'b00});
            frm('{`SNVF_OP_RDSR, 8'h00}, q);
            chk(q[1] & 8'h0C, {4'h0, b[1:0], 2'b00});
            wr(PA[b-1], 8'h77);
            rd(PA[b-1], OLD[b-1]);
        end
        wrsr(8'h00);
    endtask
    task automatic t_nv();
        wr(16'h0200, 8'hAA);
        wr(16'h0300, 8'h11);
        op(`SNVF_OP_STORE);
        wait_busy(1'b1, 20);
        chk(pin_lvl, 1'b0);
        wr(16'h0300, 8'hCC);
        wait_busy(1'b0, 600);
        @(negedge clk);
        chk({bsy_oe, bsy_o}, 2'b11);
        repeat (`SNVF_RELEASE_CYC + 4) @(negedge clk);
        chk({bsy_oe, pin_lvl}, 2'b01);
        rd(16'h0300, 8'h11);
        wr(16'h0200, 8'hBB);
        op(`SNVF_OP_RECALL);
        frm('{`SNVF_OP_RDSR, 8'h00}, q);
        chk(q[1][0], 1'b1);
        wait_busy(1'b0, 300);
        rd(16'h0200, 8'hAA);
    endtask
    task automatic t_hw();
        ext_low = 1'b1;
        repeat (8) @(negedge clk);
        ext_low = 1'b0;
        repeat (20) @(negedge clk);
        chk(busy, 1'b0);
        wr(16'h0400, 8'h55);
        ext_low = 1'b1;
        wait_busy(1'b1, 20);
        chk(busy, 1'b1);
        ext_low = 1'b0;
        wait_busy(1'b0, 600);
        repeat (30) @(negedge clk);
        op(`SNVF_OP_STORE);
        wait_busy(1'b1, 20);
        chk(busy, 1'b1);
        wait_busy(1'b0, 600);
        repeat (30) @(negedge clk);
        op(`SNVF_OP_ASOFF);
        chk(autosave_en, 1'b0);
        wr(16'h0410, 8'h66);
        power_fail = 1'b1;
        repeat (20) @(negedge clk);
        chk(busy, 1'b0);
        power_fail = 1'b0;
        op(`SNVF_OP_ASON);
        chk(autosave_en, 1'b1);
        power_fail = 1'b1;
        wait_busy(1'b1, 20);
        chk(busy, 1'b1);
        power_fail = 1'b0;
        wait_busy(1'b0, 600);
        repeat (30) @(negedge clk);
    endtask
    task automatic t_hold();
        logic [7:0] r;
        op(`SNVF_OP_WREN);
        frm('{`SNVF_OP_WRITE, 8'h05}, q);
        op(`SNVF_OP_WREN);
        u_snvf_host_model.start();
        u_snvf_host_model.xfer(`SNVF_OP_WRITE, r);
        u_snvf_host_model.xfer(8'h05, r);
        u_snvf_host_model.xfer(8'h10, r);
        #16 hold_n = 1'b0;
        #16 u_snvf_host_model.xfer(8'hFF, r);
        #16 hold_n = 1'b1;
        #16 u_snvf_host_model.xfer(8'h3C, r);
        u_snvf_host_model.stop();
        rd(16'h0510, 8'h3C);
        // Hold in the middle of a read must freeze the output shifter
        u_snvf_host_model.start();
        u_snvf_host_model.xfer(`SNVF_OP_READ, r);
        u_snvf_host_model.xfer(8'h05, r);
        u_snvf_host_model.xfer(8'h10, r);
        chk(so_oe, 1'b1);
        #16 hold_n = 1'b0;
        #16 u_snvf_host_model.xfer(8'h00, r);
        #16 hold_n = 1'b1;
        #16 u_snvf_host_model.xfer(8'h00, r);
        u_snvf_host_model.stop();
        chk(r, 8'h3C);
        chk(so_oe, 1'b0);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        resetn     = 1'b0;
        wp_n       = 1'b1;
        hold_n     = 1'b1;
        power_fail = 1'b0;
        ext_low    = 1'b0;
        num_errors = 0;
        n_tests    = 0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        t_rw();
        t_prot();
        t_nv();
        t_hw();
        t_hold();
        final_report();
    end
endmodule
